// ---- core/ctd_defines.svh ----
// constants for the capacitive touch detect logic
`ifndef CTD_DEFINES_SVH
`define CTD_DEFINES_SVH
`define CTD_CLK_HZ          25000000
`define CTD_OSC_HALF_NS     20000
`define CTD_OSC_HALF_CYC    ((`CTD_OSC_HALF_NS * 25) / 1000)
`define CTD_JITTER_PCT      4
`define CTD_JITTER_CYC      ((`CTD_OSC_HALF_CYC * `CTD_JITTER_PCT) / 100)
`define CTD_PUMP_NS         4000
`define CTD_PUMP_CYC        ((`CTD_PUMP_NS * 25 + 999) / 1000)
`define CTD_RUN_LEN         8
`define CTD_HOLD_NS         10000000
`define CTD_HOLD_CYC        ((`CTD_HOLD_NS / 1000) * 25)
`define CTD_LFSR_SEED       16'hACE1
`endif

// ---- core/ctd_pkg.sv ----
// types for the capacitive touch detect logic
package ctd_pkg;
	typedef enum logic [1:0] {CTD_PUSH, CTD_TOGGLE, CTD_PULSE} ctd_mode_t;
	typedef enum logic [1:0] {CTD_CHARGE, CTD_DISCHARGE, CTD_DECIDE} ctd_phase_t;
endpackage : ctd_pkg

// ---- core/ctd_pump_timer.sv ----
// fixed-length one-shot used for each charge pump step
`include "ctd_defines.svh"
module ctd_pump_timer #(
	parameter int LEN = `CTD_PUMP_CYC
) (
	input  wire logic clk_i,
	input  wire logic resetn_i,
	input  wire logic fire_i,
	output logic      active_o
);
	logic [15:0] cnt;

	// retrigger is not possible: a pump step is at most one per sample
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			cnt <= 16'h0000;
		else if (fire_i)
			cnt <= 16'(LEN);
		else if (cnt != 16'h0000)
			cnt <= cnt - 16'h0001;
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			active_o <= 1'b0;
		else
			active_o <= fire_i || (cnt > 16'h0001);
	end
endmodule : ctd_pump_timer

// ---- core/ctd_touch_logic.sv ----
// decision, run counter and output behaviour of the touch switch
// Notes on behaviour
// R1 - both RC charge switches share sample timing
// R2 - one sample spans two oscillator periods
// R3 - oscillator period jittered 4 % pseudo-randomly
// R4 - find which comparator went low first
// R5 - reference first gives one raise_pulse
// R6 - sensor first gives one lower_pulse
// R7 - raise_pulse charges cap fixed time
// R8 - lower_pulse sinks cap fixed time
// R9 - count consecutive same-direction pulses
// R10 - direction change clears the counter
// R11 - output only after enough consecutive pulses
// R12 - alternating pulses keep output inactive
// R13 - push mode: output follows event
// R14 - toggle mode: each event flips output
// R15 - pulse mode: fixed hold, ignore events
// R16 - threshold is parameter, counter saturates
// R17 - reset clears counter, direction, output
`include "ctd_defines.svh"
module ctd_touch_logic #(
	parameter int RUN_LEN  = `CTD_RUN_LEN,
	parameter int HALF_CYC = `CTD_OSC_HALF_CYC,
	parameter int JIT_CYC  = `CTD_JITTER_CYC,
	parameter int HOLD_CYC = `CTD_HOLD_CYC
) (
	input  wire logic              clk_i,
	input  wire logic              resetn_i,
	input  wire logic              ref_cmp_i,
	input  wire logic              sns_cmp_i,
	input  wire ctd_pkg::ctd_mode_t mode_i,
	output logic                   rc_charge_o,
	output logic                   raise_pulse_o,
	output logic                   lower_pulse_o,
	output logic                   switch_out_o
);
	logic [15:0]         lfsr;
	logic [15:0]         tick_cnt;
	logic [15:0]         next_tick_len;
	logic                tick;
	logic                osc_phase;
	ctd_pkg::ctd_phase_t phase;
	logic                ref_first;
	logic                sns_first;
	logic                decided;
	logic                sample_end;
	logic                last_dir;
	logic                dir_valid;
	logic [7:0]          run_cnt;
	logic                event_lvl;
	logic                event_prev;
	logic [31:0]         hold_cnt;
	logic                fire_up;
	logic                fire_dn;
	logic                up_act;
	logic                dn_act;

	// pseudo-random source for the period jitter
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			lfsr <= `CTD_LFSR_SEED;
		else if (tick)
			lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
	end

	// half period shortened or lengthened by the jitter span
	always_comb
	begin
		next_tick_len = lfsr[0] ? 16'(HALF_CYC + JIT_CYC) : 16'(HALF_CYC - JIT_CYC); // [R3]
		tick = (tick_cnt == 16'h0000);
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			tick_cnt <= 16'(HALF_CYC);
		else if (tick)
			tick_cnt <= next_tick_len - 16'h0001; // [R3]
		else
			tick_cnt <= tick_cnt - 16'h0001;
	end

	// two oscillator half periods per phase, so one sample is two full periods
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			osc_phase <= 1'b0;
		else if (tick)
			osc_phase <= ~osc_phase;
	end

	assign sample_end = tick && osc_phase && (phase == ctd_pkg::CTD_DISCHARGE); // [R2]

	// charge phase then discharge phase, same switch drive for both RC nets
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			phase <= ctd_pkg::CTD_CHARGE;
		else if (tick && osc_phase)
		begin
			unique case (phase)
				ctd_pkg::CTD_CHARGE:    phase <= ctd_pkg::CTD_DISCHARGE;
				ctd_pkg::CTD_DISCHARGE: phase <= ctd_pkg::CTD_CHARGE;
				ctd_pkg::CTD_DECIDE:    phase <= ctd_pkg::CTD_CHARGE;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			rc_charge_o <= 1'b0;
		else
			rc_charge_o <= (phase == ctd_pkg::CTD_CHARGE); // [R1]
	end

	// first comparator to fall in the discharge phase wins; a tie favours raise
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			ref_first <= 1'b0;
			sns_first <= 1'b0;
			decided   <= 1'b0;
		end
		else if (phase != ctd_pkg::CTD_DISCHARGE)
		begin
			ref_first <= 1'b0;
			sns_first <= 1'b0;
			decided   <= 1'b0;
		end
		else if (!decided && (!ref_cmp_i || !sns_cmp_i)) // [R4]
		begin
			ref_first <= !ref_cmp_i;
			sns_first <= ref_cmp_i;
			decided   <= 1'b1;
		end
	end

	// one pump request per sample; no decision means no step
	assign fire_up = sample_end && ref_first; // [R5]
	assign fire_dn = sample_end && sns_first; // [R6]

	ctd_pump_timer #(.LEN(`CTD_PUMP_CYC)) u_up (
		.clk_i    (clk_i),
		.resetn_i (resetn_i),
		.fire_i   (fire_up),
		.active_o (up_act)
	);

	ctd_pump_timer #(.LEN(`CTD_PUMP_CYC)) u_dn (
		.clk_i    (clk_i),
		.resetn_i (resetn_i),
		.fire_i   (fire_dn),
		.active_o (dn_act)
	);

	// pump enables are registered copies so outputs stay glitch free
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			raise_pulse_o <= 1'b0;
			lower_pulse_o <= 1'b0;
		end
		else
		begin
			raise_pulse_o <= up_act; // [R7]
			lower_pulse_o <= dn_act; // [R8]
		end
	end

	// run counter with direction memory, saturating at the threshold
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			run_cnt   <= 8'h00; // [R17]
			last_dir  <= 1'b0;
			dir_valid <= 1'b0;
		end
		else if (fire_up || fire_dn)
		begin
			last_dir  <= fire_up;
			dir_valid <= 1'b1;
			if (dir_valid && (last_dir != fire_up))
				run_cnt <= 8'h01; // [R10] [R12]
			else if (run_cnt < 8'(RUN_LEN))
				run_cnt <= run_cnt + 8'h01; // [R9] [R16]
		end
	end

	// event means a long run of raise pulses: added plate capacitance slows the sensor net,
	// so the reference comparator keeps falling first
	assign event_lvl = dir_valid && last_dir && (run_cnt >= 8'(RUN_LEN)); // [R11]

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			event_prev <= 1'b0;
		else
			event_prev <= event_lvl;
	end

	// pulse mode hold timer; events while it runs are dropped
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			hold_cnt <= 32'h0000_0000;
		else if (mode_i == ctd_pkg::CTD_PULSE && hold_cnt == 32'h0000_0000
			&& event_lvl && !event_prev)
			hold_cnt <= 32'(HOLD_CYC); // [R15]
		else if (hold_cnt != 32'h0000_0000)
			hold_cnt <= hold_cnt - 32'h0000_0001;
	end

	// output behaviour per mode
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			switch_out_o <= 1'b0; // [R17]
		else
		begin
			unique case (mode_i)
				ctd_pkg::CTD_PUSH:   switch_out_o <= event_lvl; // [R13]
				ctd_pkg::CTD_TOGGLE:
					if (event_lvl && !event_prev)
						switch_out_o <= ~switch_out_o; // [R14]
				ctd_pkg::CTD_PULSE:  switch_out_o <= (hold_cnt > 32'h0000_0001)
					|| (event_lvl && !event_prev && hold_cnt == 32'h0000_0000); // [R15]
				default:             switch_out_o <= 1'b0;
			endcase
		end
	end
endmodule : ctd_touch_logic

// ---- tb/ctd_touch_checker.sv ----
// port assertions for the touch decision logic
module ctd_touch_checker #(
	parameter int RUN_LEN  = 8,
	parameter int HALF_CYC = 500,
	parameter int JIT_CYC  = 20,
	parameter int HOLD_CYC = 250000
) (
	input  wire logic               clk_i,
	input  wire logic               resetn_i,
	input  wire logic               ref_cmp_i,
	input  wire logic               sns_cmp_i,
	input  wire ctd_pkg::ctd_mode_t mode_i,
	input  wire logic               rc_charge_o,
	input  wire logic               raise_pulse_o,
	input  wire logic               lower_pulse_o,
	input  wire logic               switch_out_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// charge phase is two jittered half periods; the first after reset runs one cycle long
	localparam int PH_LO = 2 * HALF_CYC - 2 * JIT_CYC;
	localparam int PH_HI = 2 * HALF_CYC + 2 * JIT_CYC + 1;
	logic [31:0] ch_cnt;
	logic [31:0] hi_cnt;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	// high-time counters: full-size timing is far beyond what a delay may span
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			ch_cnt <= 32'h0000_0000;
		else if (rc_charge_o)
			ch_cnt <= ch_cnt + 32'h0000_0001;
		else
			ch_cnt <= 32'h0000_0000;
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			hi_cnt <= 32'h0000_0000;
		else if (switch_out_o)
			hi_cnt <= hi_cnt + 32'h0000_0001;
		else
			hi_cnt <= 32'h0000_0000;
	end

	// pump steps never overlap and last a fixed time
	pump_excl_a: assert property (!(raise_pulse_o && lower_pulse_o))
		else $error("raise and lower pump both on");
	raise_len_a: assert property ($rose(raise_pulse_o) |-> ##99 raise_pulse_o ##1 !raise_pulse_o)
		else $error("raise pump step length wrong");
	lower_len_a: assert property ($rose(lower_pulse_o) |-> ##99 lower_pulse_o ##1 !lower_pulse_o)
		else $error("lower pump step length wrong");
	charge_len_a: assert property ($fell(rc_charge_o)
		|-> ch_cnt >= 32'(PH_LO) && ch_cnt <= 32'(PH_HI))
		else $error("charge phase length wrong");
	// output behaviour per mode
	push_rise_a: assert property ($rose(switch_out_o) && mode_i == ctd_pkg::CTD_PUSH
		|-> ##[0:3] raise_pulse_o)
		else $error("push output rose without raise step");
	push_drop_a: assert property (mode_i == ctd_pkg::CTD_PUSH && $rose(lower_pulse_o)
		|-> ##[0:3] !switch_out_o)
		else $error("push output outlived the event");
	toggle_sync_a: assert property ($changed(switch_out_o) && mode_i == ctd_pkg::CTD_TOGGLE
		|-> ##[0:2] raise_pulse_o)
		else $error("toggle output changed without event");
	pulse_hold_a: assert property ($fell(switch_out_o) && mode_i == ctd_pkg::CTD_PULSE
		|-> hi_cnt == 32'(HOLD_CYC))
		else $error("pulse output hold wrong");
	pulse_limit_a: assert property (mode_i == ctd_pkg::CTD_PULSE
		|-> hi_cnt <= 32'(HOLD_CYC))
		else $error("pulse output held too long");
	reset_clear_a: assert property ($rose(resetn_i)
		|-> !switch_out_o && !raise_pulse_o && !lower_pulse_o)
		else $error("outputs not cleared by reset");
	push_c: cover property (mode_i == ctd_pkg::CTD_PUSH && $rose(switch_out_o));
	toggle_c: cover property (mode_i == ctd_pkg::CTD_TOGGLE && $fell(switch_out_o));
	pulse_c: cover property (mode_i == ctd_pkg::CTD_PULSE && $fell(switch_out_o));
endmodule : ctd_touch_checker

bind ctd_touch_logic ctd_touch_checker #(.RUN_LEN(RUN_LEN), .HALF_CYC(HALF_CYC),
	.JIT_CYC(JIT_CYC), .HOLD_CYC(HOLD_CYC)) i_ctd_touch_checker (.clk_i, .resetn_i,
	.ref_cmp_i, .sns_cmp_i, .mode_i, .rc_charge_o, .raise_pulse_o, .lower_pulse_o,
	.switch_out_o);

// ---- tb/ctd_front_model.sv ----
// comparator front end answering the charge switch
module ctd_front_model (
	input  wire logic       clk_i,
	input  wire logic       rc_charge_i,
	input  wire logic [7:0] ref_dly_i,
	input  wire logic [7:0] sns_dly_i,
	output logic            ref_cmp_o,
	output logic            sns_cmp_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] dis_cnt = 8'h00;
	// both nets discharge from the same edge; count saturates so no wrap re-arms them
	always_ff @(posedge clk_i)
	begin
		dis_cnt <= rc_charge_i ? 8'h00 : dis_cnt + {7'h00, dis_cnt != 8'hFF};
		ref_cmp_o <= rc_charge_i || (dis_cnt < ref_dly_i);
		sns_cmp_o <= rc_charge_i || (dis_cnt < sns_dly_i);
	end
endmodule : ctd_front_model

// ---- tb/ctd_touch_logic_tb.sv ----
// self-checking bench for the touch decision logic
module ctd_touch_logic_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic               clk_i = 1'b0;
	logic               resetn_i = 1'b0;
	ctd_pkg::ctd_mode_t mode_i = ctd_pkg::CTD_PUSH;
	logic [7:0]         ref_dly = 8'h0A;
	logic [7:0]         sns_dly = 8'h1E;
	logic               ref_cmp, sns_cmp, rc_charge, raise_pulse, lower_pulse, switch_out;
	int                 fails = 0;
	int                 check_count = 0;

	always #20 clk_i = ~clk_i;

	// short half period keeps the run brief; hold spans many samples so a repeat event lands in it
	ctd_touch_logic #(.HALF_CYC(40), .JIT_CYC(1), .HOLD_CYC(2000)) i_ctd_touch_logic (.clk_i,
		.resetn_i, .ref_cmp_i(ref_cmp), .sns_cmp_i(sns_cmp), .mode_i, .rc_charge_o(rc_charge),
		.raise_pulse_o(raise_pulse), .lower_pulse_o(lower_pulse), .switch_out_o(switch_out));
	ctd_front_model i_ctd_front_model (.clk_i, .rc_charge_i(rc_charge), .ref_dly_i(ref_dly),
		.sns_dly_i(sns_dly), .ref_cmp_o(ref_cmp), .sns_cmp_o(sns_cmp));

	task automatic check(input string what, input logic exp, input logic got);
		check_count++;
		if (got !== exp)
		begin
			fails++;
			$display("wrong value %s expected %b seen %b", what, exp, got);
		end
	endtask : check

	task automatic do_reset(input ctd_pkg::ctd_mode_t m);
		@(negedge clk_i);
		resetn_i = 1'b0;
		mode_i = m;
		repeat (20) @(negedge clk_i);
		check("switch in reset", 1'b0, switch_out);
		resetn_i = 1'b1;
	endtask : do_reset

	// n samples with the sensor slow (raise) or fast (lower); each must give one matching step
	task automatic samples(input logic slow, input int n);
		int t;
		t = 0;
		while (rc_charge !== 1'b1 && t < 400)
		begin
			@(negedge clk_i);
			t++;
		end
		ref_dly = slow ? 8'h0A : 8'h1E;
		sns_dly = slow ? 8'h1E : 8'h0A;
		repeat (n)
		begin
			t = 0;
			while (rc_charge !== 1'b0 && t < 400)
			begin
				@(negedge clk_i);
				t++;
			end
			while (rc_charge !== 1'b1 && t < 400)
			begin
				@(negedge clk_i);
				t++;
			end
			check("charge phase seen", 1'b1, rc_charge);
			repeat (5) @(negedge clk_i);
			check("lower step", ~slow, lower_pulse);
			check("raise step", slow, raise_pulse);
		end
	endtask : samples

	task automatic t_equil();
		do_reset(ctd_pkg::CTD_PUSH);
		repeat (8)
		begin
			samples(1'b1, 1);
			samples(1'b0, 1);
			check("switch in balance", 1'b0, switch_out);
		end
		$display("test balance done");
	endtask : t_equil

	task automatic t_push();
		do_reset(ctd_pkg::CTD_PUSH);
		samples(1'b1, 7);
		check("push after 7", 1'b0, switch_out);
		samples(1'b1, 1);
		check("push after 8", 1'b1, switch_out);
		samples(1'b1, 3);
		check("push held", 1'b1, switch_out);
		samples(1'b0, 1);
		check("push released", 1'b0, switch_out);
		samples(1'b1, 7);
		check("push run restarted", 1'b0, switch_out);
		$display("test push done");
	endtask : t_push

	task automatic t_toggle();
		do_reset(ctd_pkg::CTD_TOGGLE);
		samples(1'b1, 8);
		check("toggle on", 1'b1, switch_out);
		samples(1'b0, 1);
		check("toggle kept", 1'b1, switch_out);
		samples(1'b1, 8);
		check("toggle off", 1'b0, switch_out);
		$display("test toggle done");
	endtask : t_toggle

	task automatic t_pulse();
		do_reset(ctd_pkg::CTD_PULSE);
		samples(1'b1, 8);
		check("pulse on", 1'b1, switch_out);
		samples(1'b0, 1);
		samples(1'b1, 8);
		check("pulse kept through repeat", 1'b1, switch_out);
		samples(1'b1, 5);
		check("pulse ended", 1'b0, switch_out);
		$display("test pulse done");
	endtask : t_pulse

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : print_verdict

	// main sequence
	initial
	begin
		t_equil();
		t_push();
		t_toggle();
		t_pulse();
		print_verdict();
	end

	// watchdog well beyond the roughly 12000 cycles the tests need
	initial
	begin
		repeat (40000) @(posedge clk_i);
		fails++;
		print_verdict();
	end
endmodule : ctd_touch_logic_tb
